// ===== src/clpf_framer.v
// data link framer: packet wrap/pad on transmit, find/check/unwrap on receive
// assumes network layer and link slot share clk_in; link takes one char per beat
`timescale 1ns/100ps
`include "clpf_defines.vh"

module clpf_framer #(
  parameter             CRC_W    = 16,
  parameter [CRC_W-1:0] CRC_POLY = `CLPF_CRC_POLY,
  parameter [CRC_W-1:0] CRC_INIT = `CLPF_CRC_INIT
) (
  input  wire       clk_in,
  input  wire       arst_n_in,
  input  wire       sync_mode_in,
  input  wire [8:0] payload_length_chars_in,
  input  wire       tx_valid_in,
  input  wire [7:0] tx_data_in,
  input  wire       tx_last_in,
  output wire       tx_ready_out,
  output reg        tx_reject_out,
  output reg        tx_char_valid_out,
  output reg  [7:0] tx_char_out,
  output reg        tx_frame_last_out,
  input  wire       tx_link_ready_in,
  input  wire       rx_char_valid_in,
  input  wire [7:0] rx_char_in,
  input  wire       rx_frame_end_in,
  output reg        rx_valid_out,
  output reg  [7:0] rx_data_out,
  output reg        rx_last_out,
  input  wire       rx_ready_in,
  output reg        rx_good_out,
  output reg        rx_drop_out
);

  //////////////////////////////////////////////////////////////////////////////
  // reset release and shared helpers

  reg rst_meta_q;
  reg rst_n_q;

  always @(posedge clk_in or negedge arst_n_in)
  begin
    if (!arst_n_in)
    begin
      rst_meta_q <= 1'b0;
      rst_n_q    <= 1'b0;
    end
    else
    begin
      rst_meta_q <= 1'b1;
      rst_n_q    <= rst_meta_q;
    end
  end

  // msb-first crc, one character per call
  function [CRC_W-1:0] crc_step;
    input [CRC_W-1:0] crc;
    input [7:0]       ch;
    integer           i;
    reg   [CRC_W-1:0] c;
    begin
      c = crc;
      for (i = 7; i >= 0; i = i - 1)
        c = (c[CRC_W-1] ^ ch[i]) ? ((c << 1) ^ CRC_POLY) : (c << 1);
      crc_step = c;
    end
  endfunction

  function [7:0] hex_char;
    input [3:0] n;
    begin
      hex_char = (n < 4'ha) ? (`CLPF_CHAR_ZERO + {4'h0, n})
                            : (`CLPF_HEX_UP_OFS + {4'h0, n});
    end
  endfunction

  // {bad, nibble}
  function [4:0] hex_val;
    input [7:0] c;
    reg   [7:0] t;
    begin
      t = 8'h00;
      hex_val = 5'h10;
      if (c >= `CLPF_CHAR_ZERO && c <= `CLPF_CHAR_NINE)
      begin
        t = c - `CLPF_CHAR_ZERO;
        hex_val = {1'b0, t[3:0]};
      end
      else if (c >= `CLPF_CHAR_UA && c <= `CLPF_CHAR_UF)
      begin
        t = c - `CLPF_HEX_UP_OFS;
        hex_val = {1'b0, t[3:0]};
      end
      else if (c >= `CLPF_CHAR_LA && c <= `CLPF_CHAR_LF_HEX)
      begin
        t = c - `CLPF_HEX_LO_OFS;
        hex_val = {1'b0, t[3:0]};
      end
    end
  endfunction

  //////////////////////////////////////////////////////////////////////////////
  // transmit loader: buffers the whole network packet, crc computed on the fly

  reg [7:0]       tmem [0:`CLPF_MEM_DEPTH-1];
  reg [8:0]       lcnt_q;
  reg             have_pkt_q;
  reg             lover_q;
  reg [8:0]       tlen_q;
  reg [CRC_W-1:0] lcrc_q;
  reg [CRC_W-1:0] tcrc_q;
  wire [8:0]      lcnt_nx = lcnt_q + 9'h001;
  wire            ltake   = tx_valid_in & ~have_pkt_q;
  wire [CRC_W-1:0] lcrc_nx = crc_step(lcrc_q, tx_data_in);
  wire [8:0]      ltot    = lcnt_nx + `CLPF_OVERHEAD;
  wire            lfits   = ~lover_q & (lcnt_q < `CLPF_NET_MAX) & (ltot >= `CLPF_PKT_MIN)
                            & (~sync_mode_in | (ltot <= payload_length_chars_in));
  reg             send_done;

  assign tx_ready_out = ~have_pkt_q;

  always @(posedge clk_in)
    if (ltake && lcnt_q < `CLPF_NET_MAX)
      tmem[lcnt_q[7:0]] <= tx_data_in;

  always @(posedge clk_in or negedge rst_n_q)
  begin
    if (!rst_n_q)
    begin
      lcnt_q        <= 9'h000;
      have_pkt_q    <= 1'b0;
      lover_q       <= 1'b0;
      tlen_q        <= 9'h000;
      lcrc_q        <= CRC_INIT;
      tcrc_q        <= CRC_INIT;
      tx_reject_out <= 1'b0;
    end
    else
    begin
      tx_reject_out <= 1'b0;
      if (send_done)
        have_pkt_q <= 1'b0;
      if (ltake)
      begin
        if (tx_last_in)
        begin
          lcnt_q  <= 9'h000;
          lover_q <= 1'b0;
          lcrc_q  <= CRC_INIT;
          if (lfits)
          begin
            have_pkt_q <= 1'b1;
            tlen_q     <= lcnt_nx;
            tcrc_q     <= lcrc_nx;
          end
          else
            tx_reject_out <= 1'b1;
        end
        else
        begin
          if (lcnt_q < `CLPF_NET_MAX)
            lcnt_q <= lcnt_nx;
          else
            lover_q <= 1'b1;
          lcrc_q <= lcrc_nx;
        end
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // transmit sender: start, body, checksum, end, then padding to frame end in sync mode

  localparam [2:0] S_IDLE  = 3'h0;
  localparam [2:0] S_BODY  = 3'h1;
  localparam [2:0] S_CRC   = 3'h2;
  localparam [2:0] S_END   = 3'h3;
  localparam [2:0] S_PAD   = 3'h4;

  reg [2:0] sst_q;
  reg [2:0] sst_d;
  reg [8:0] ridx_q;
  reg [8:0] ridx_d;
  reg [8:0] fcnt_q;
  reg [8:0] fcnt_d;
  reg       emit;
  reg [7:0] ech;
  reg       elast;
  wire      adv      = ~tx_char_valid_out | tx_link_ready_in;
  wire      fr_last  = (fcnt_q == payload_length_chars_in - 9'h001);
  wire [3:0] crc_nib = tcrc_q[(CRC_W-1)-{ridx_q[1:0], 2'b00} -: 4];

  always @*
  begin
    sst_d     = sst_q;
    ridx_d    = ridx_q;
    emit      = 1'b0;
    ech       = `CLPF_CHAR_PAD;
    elast     = 1'b0;
    send_done = 1'b0;
    if (adv)
    begin
      case (sst_q)
        S_IDLE:
        begin
          if (have_pkt_q && (!sync_mode_in || fcnt_q == 9'h000))
          begin
            emit   = 1'b1;
            ech    = `CLPF_CHAR_START;
            ridx_d = 9'h000;
            sst_d  = S_BODY;
          end
          else if (sync_mode_in)
          begin
            emit = 1'b1;
            ech  = `CLPF_CHAR_PAD;
          end
        end
        S_BODY:
        begin
          emit   = 1'b1;
          ech    = tmem[ridx_q[7:0]];
          ridx_d = ridx_q + 9'h001;
          if (ridx_d == tlen_q)
          begin
            ridx_d = 9'h000;
            sst_d  = S_CRC;
          end
        end
        S_CRC:
        begin
          emit   = 1'b1;
          ech    = hex_char(crc_nib);
          ridx_d = ridx_q + 9'h001;
          if (ridx_d == `CLPF_CRC_CHARS)
            sst_d = S_END;
        end
        S_END:
        begin
          emit      = 1'b1;
          ech       = `CLPF_CHAR_END;
          send_done = 1'b1;
          sst_d     = (sync_mode_in && !fr_last) ? S_PAD : S_IDLE;
        end
        S_PAD:
        begin
          emit = 1'b1;
          ech  = `CLPF_CHAR_PAD;
          if (fr_last)
            sst_d = S_IDLE;
        end
        default:
          sst_d = S_IDLE;
      endcase
      // async: the field is just the packet, no padding around it
      if (sync_mode_in)
        elast = fr_last;
      else
        elast = (sst_q == S_END);
    end
  end

  always @*
  begin
    fcnt_d = fcnt_q;
    if (emit)
      fcnt_d = elast ? 9'h000 : fcnt_q + 9'h001;
  end

  always @(posedge clk_in or negedge rst_n_q)
  begin
    if (!rst_n_q)
    begin
      sst_q             <= S_IDLE;
      ridx_q            <= 9'h000;
      fcnt_q            <= 9'h000;
      tx_char_valid_out <= 1'b0;
      tx_char_out       <= 8'h00;
      tx_frame_last_out <= 1'b0;
    end
    else
    begin
      sst_q  <= sst_d;
      ridx_q <= ridx_d;
      fcnt_q <= fcnt_d;
      if (adv)
      begin
        tx_char_valid_out <= emit;
        tx_char_out       <= ech;
        tx_frame_last_out <= emit & elast;
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // receiver: last four body chars held back, they may be the checksum

  localparam [1:0] R_IDLE = 2'h0;
  localparam [1:0] R_PKT  = 2'h1;
  localparam [1:0] R_OUT  = 2'h2;

  reg [7:0]       rmem [0:`CLPF_MEM_DEPTH-1];
  reg [1:0]       rst_q;
  reg [8:0]       rcnt_q;
  reg [31:0]      sh_q;
  reg [CRC_W-1:0] rcrc_q;
  reg [8:0]       olen_q;
  reg [8:0]       oidx_q;
  wire [4:0]      h3 = hex_val(sh_q[31:24]);
  wire [4:0]      h2 = hex_val(sh_q[23:16]);
  wire [4:0]      h1 = hex_val(sh_q[15:8]);
  wire [4:0]      h0 = hex_val(sh_q[7:0]);
  wire            hex_bad = h3[4] | h2[4] | h1[4] | h0[4];
  wire [15:0]     rx_sum  = {h3[3:0], h2[3:0], h1[3:0], h0[3:0]};
  wire [8:0]      rtot    = rcnt_q + 9'h002;
  wire            rlen_ok = (rcnt_q >= `CLPF_CRC_CHARS) & (rtot >= `CLPF_PKT_MIN);
  wire            rmatch  = ~hex_bad & (rx_sum == rcrc_q[15:0]);
  wire            rch     = rx_char_valid_in;
  wire            rstore  = rch & (rst_q == R_PKT) & (rx_char_in != `CLPF_CHAR_END)
                            & (rx_char_in != `CLPF_CHAR_START) & (rcnt_q >= `CLPF_CRC_CHARS);
  wire [8:0]      widx    = rcnt_q - `CLPF_CRC_CHARS;
  wire [8:0]      oidx_nx = oidx_q + 9'h001;

  always @(posedge clk_in)
    if (rstore)
      rmem[widx[7:0]] <= sh_q[31:24];

  always @(posedge clk_in or negedge rst_n_q)
  begin
    if (!rst_n_q)
    begin
      rst_q        <= R_IDLE;
      rcnt_q       <= 9'h000;
      sh_q         <= 32'h0000_0000;
      rcrc_q       <= CRC_INIT;
      olen_q       <= 9'h000;
      oidx_q       <= 9'h000;
      rx_valid_out <= 1'b0;
      rx_data_out  <= 8'h00;
      rx_last_out  <= 1'b0;
      rx_good_out  <= 1'b0;
      rx_drop_out  <= 1'b0;
    end
    else
    begin
      rx_good_out <= 1'b0;
      rx_drop_out <= 1'b0;
      case (rst_q)
        R_IDLE:
        begin
          if (rch && rx_char_in == `CLPF_CHAR_START && !rx_frame_end_in)
          begin
            rst_q  <= R_PKT;
            rcnt_q <= 9'h000;
            rcrc_q <= CRC_INIT;
          end
        end
        R_PKT:
        begin
          if (rch && rx_char_in == `CLPF_CHAR_END)
          begin
            if (rlen_ok && rmatch)
            begin
              rst_q        <= R_OUT;
              olen_q       <= widx;
              oidx_q       <= 9'h000;
              rx_good_out  <= 1'b1;
              rx_valid_out <= 1'b1;
              rx_data_out  <= rmem[0];
              rx_last_out  <= (widx == 9'h001);
            end
            else
            begin
              rst_q       <= R_IDLE;
              rx_drop_out <= 1'b1;
            end
          end
          else if (rch && (rx_frame_end_in || rtot >= `CLPF_PKT_MAX))
          begin
            rst_q       <= R_IDLE;
            rx_drop_out <= 1'b1;
          end
          else if (rch && rx_char_in == `CLPF_CHAR_START)
          begin
            // resync on a fresh start; the broken one is lost
            rcnt_q      <= 9'h000;
            rcrc_q      <= CRC_INIT;
            rx_drop_out <= 1'b1;
          end
          else if (rch)
          begin
            sh_q   <= {sh_q[23:0], rx_char_in};
            rcnt_q <= rcnt_q + 9'h001;
            if (rcnt_q >= `CLPF_CRC_CHARS)
              rcrc_q <= crc_step(rcrc_q, sh_q[31:24]);
          end
        end
        R_OUT:
        begin
          // link chars arriving here are lost: no room to hold a second packet
          if (rx_ready_in)
          begin
            if (rx_last_out)
            begin
              rx_valid_out <= 1'b0;
              rx_last_out  <= 1'b0;
              rst_q        <= R_IDLE;
            end
            else
            begin
              oidx_q      <= oidx_nx;
              rx_data_out <= rmem[oidx_nx[7:0]];
              rx_last_out <= (oidx_nx == olen_q - 9'h001);
            end
          end
        end
        default:
          rst_q <= R_IDLE;
      endcase
    end
  end

endmodule // clpf_framer

// ===== src/clpf_defines.vh
// constants for the control link packet framer
// assumes one character clock; characters are 8-bit codes
//
// How it works
// - each frame carries one payload field: packet, padding or both, of configured length; async frames here end at the packet's end character.
// - synchronous links keep the payload length constant frame to frame.
// - payload field length exceeds 32 and is at most 256 characters.
// - synchronous transmit pads unused or empty payload positions.
// - asynchronous transmit sends packets when ready, without padding.
// - packet fields follow each other with no separator.
// - whole packet, start to end inclusive, is 32 to 256 characters.
// - first packet character is line feed.
// - four hex checksum characters over network packet follow it directly.
// - last packet character is carriage return.
// - every padding character is carriage return.
// - transmitter computes checksum first, then sends start, body, checksum, end.
// - receiver starts on line feed and counts characters to carriage return.
// - frame ending before the end character drops the partial packet.
// - matching checksum passes the network packet upward.
// - mismatching checksum drops the packet, nothing forwarded.
`ifndef CLPF_DEFINES_VH
`define CLPF_DEFINES_VH

`define CLPF_CHAR_START    8'h0a
`define CLPF_CHAR_END      8'h0d
`define CLPF_CHAR_PAD      8'h0d
`define CLPF_CHAR_ZERO     8'h30
`define CLPF_CHAR_NINE     8'h39
`define CLPF_CHAR_UA       8'h41
`define CLPF_CHAR_UF       8'h46
`define CLPF_CHAR_LA       8'h61
`define CLPF_CHAR_LF_HEX   8'h66
`define CLPF_HEX_UP_OFS    8'h37
`define CLPF_HEX_LO_OFS    8'h57

// lengths in characters
`define CLPF_PKT_MIN       9'h020
`define CLPF_PKT_MAX       9'h100
`define CLPF_PAY_MIN       9'h021
`define CLPF_OVERHEAD      9'h006
`define CLPF_CRC_CHARS     9'h004
`define CLPF_NET_MAX       9'h0fa
`define CLPF_MEM_DEPTH     256

`define CLPF_CRC_POLY      16'h1021
`define CLPF_CRC_INIT      16'hffff

`endif

// ===== testbench/clpf_framer_asserts.sv
// port checker for the control link packet framer
// assumes it is bound onto clpf_framer; one clock domain
`timescale 1ns/100ps
module clpf_framer_asserts (
  input logic       clk_in,
  input logic       arst_n_in,
  input logic       sync_mode_in,
  input logic       tx_valid_in,
  input logic       tx_last_in,
  input logic       tx_ready_out,
  input logic       tx_reject_out,
  input logic       tx_char_valid_out,
  input logic [7:0] tx_char_out,
  input logic       tx_frame_last_out,
  input logic       tx_link_ready_in,
  input logic       rx_valid_out,
  input logic [7:0] rx_data_out,
  input logic       rx_ready_in,
  input logic       rx_good_out,
  input logic       rx_drop_out
);
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!arst_n_in);
  //////////////////////////////////////////////////////////////
  sequence s_last_taken;
    tx_valid_in && tx_ready_out && tx_last_in;
  endsequence
  sequence s_adv;
    tx_char_valid_out && tx_link_ready_in;
  endsequence
  property p_tx_answer;
    s_last_taken |=> !tx_ready_out || tx_reject_out;
  endproperty
  a_tx_answer: assert property (p_tx_answer) else $error("packet end unanswered");
  property p_rej_cause;
    tx_reject_out |-> $past(tx_valid_in && tx_last_in);
  endproperty
  a_rej_cause: assert property (p_rej_cause) else $error("refusal without packet end");
  property p_tx_hold;
    tx_char_valid_out && !tx_link_ready_in |=> tx_char_valid_out && $stable(tx_char_out);
  endproperty
  a_tx_hold: assert property (p_tx_hold) else $error("link char changed while stalled");
  property p_async_cr;
    !sync_mode_in && tx_char_valid_out && tx_char_out == 8'h0d |-> tx_frame_last_out;
  endproperty
  a_async_cr: assert property (p_async_cr) else $error("async carriage return not frame end");
  property p_sync_cont;
    (sync_mode_in and s_adv) |=> tx_char_valid_out;
  endproperty
  a_sync_cont: assert property (p_sync_cont) else $error("sync link stream gap");
  property p_good_first;
    rx_good_out |-> rx_valid_out && !$past(rx_valid_out);
  endproperty
  a_good_first: assert property (p_good_first) else $error("good pulse without first char");
  property p_rx_hold;
    rx_valid_out && !rx_ready_in |=> rx_valid_out && $stable(rx_data_out);
  endproperty
  a_rx_hold: assert property (p_rx_hold) else $error("network char lost while held");
  property p_rx_excl;
    rx_drop_out |-> !rx_good_out ##1 !rx_drop_out;
  endproperty
  a_rx_excl: assert property (p_rx_excl) else $error("drop pulse overlaps or lasts");
endmodule // clpf_framer_asserts
bind clpf_framer clpf_framer_asserts u_chk (.*);

// ===== testbench/clpf_link_model.sv
// far side link partner: takes tx chars with stalls, sends rx frames
// assumes the bench calls send and idle; drives at the falling edge
`timescale 1ns/100ps
module clpf_link_model (
  input  logic       clk_in,
  input  logic       stall_in,
  input  logic       tx_valid_in,
  input  logic [7:0] tx_char_in,
  input  logic       tx_last_in,
  output logic       link_ready_out,
  output logic       rx_valid_out,
  output logic [7:0] rx_char_out,
  output logic       rx_end_out
);
  logic [7:0] cap[$];
  logic       fl[$];
  logic [1:0] ph = 2'h0;
  initial
  begin
    link_ready_out = 1'b1;
    rx_valid_out = 1'b0;
    rx_char_out = 8'h00;
    rx_end_out = 1'b0;
  end
  //////////////////////////////////////////////////////////////
  // one beat in three refused, so the sender must hold its char
  always @(negedge clk_in)
  begin
    ph <= (ph == 2'h2) ? 2'h0 : ph + 2'h1;
    link_ready_out <= !(stall_in && ph == 2'h0);
  end
  always @(posedge clk_in)
    if (tx_valid_in && link_ready_out)
    begin
      cap.push_back(tx_char_in);
      fl.push_back(tx_last_in);
    end
  task send(input logic [7:0] c, input logic e);
    @(negedge clk_in);
    rx_valid_out = 1'b1;
    rx_char_out = c;
    rx_end_out = e;
  endtask
  // released line shows the inverse, not a stale copy
  task idle();
    @(negedge clk_in);
    rx_valid_out = 1'b0;
    rx_end_out = 1'b0;
    rx_char_out = ~rx_char_out;
  endtask
endmodule // clpf_link_model

// ===== testbench/test_clpf_framer.sv
// self-checking bench for the control link packet framer
// assumes the link model and bound checker are compiled alongside
`timescale 1ns/100ps
`define CHK(nm, e, a) begin tests_run++; if ((e) !== (a)) begin errors++; $display("BAD %s exp %h got %h", nm, e, a); end end
module test_clpf_framer;
  logic       clk_in, arst_n_in, sync_mode_in, tx_valid_in, tx_last_in, tx_ready_out;
  logic       tx_reject_out, tx_char_valid_out, tx_frame_last_out, tx_link_ready_in;
  logic       rx_char_valid_in, rx_frame_end_in, rx_valid_out, rx_last_out, rx_ready_in;
  logic       rx_good_out, rx_drop_out, stall, rej;
  logic [8:0] payload_length_chars_in;
  logic [7:0] tx_data_in, tx_char_out, rx_char_in, rx_data_out;
  logic [7:0] body[$], exp[$], got[$];
  int         errors, tests_run, goods, drops, lastn;
  clpf_framer dut (.*);
  clpf_link_model m (.clk_in(clk_in), .stall_in(stall), .tx_valid_in(tx_char_valid_out),
    .tx_char_in(tx_char_out), .tx_last_in(tx_frame_last_out), .link_ready_out(tx_link_ready_in),
    .rx_valid_out(rx_char_valid_in), .rx_char_out(rx_char_in), .rx_end_out(rx_frame_end_in));
  always #5 clk_in = ~clk_in;
  always @(negedge clk_in) rx_ready_in <= ~rx_ready_in;
  always @(posedge clk_in)
  begin
    goods += (rx_good_out === 1'b1);
    drops += (rx_drop_out === 1'b1);
    if (rx_valid_out === 1'b1 && rx_ready_in === 1'b1)
    begin
      got.push_back(rx_data_out);
      if (rx_last_out === 1'b1) lastn = got.size();
    end
  end
  //////////////////////////////////////////////////////////////
  function automatic logic [15:0] crc_of();
    logic [15:0] c;
    c = 16'hffff;
    foreach (body[i])
    begin
      c = c ^ {body[i], 8'h00};
      repeat (8) c = c[15] ? {c[14:0], 1'b0} ^ 16'h1021 : {c[14:0], 1'b0};
    end
    return c;
  endfunction
  function automatic logic [7:0] hexc(input logic [3:0] n, input logic lo);
    return (n < 4'ha) ? 8'h30 + n : (lo ? 8'h57 : 8'h37) + n;
  endfunction
  task automatic make(input int n);
    logic [15:0] c;
    body.delete();
    for (int i = 0; i < n; i++) body.push_back(8'h30 + 8'(i % 64));
    c = crc_of();
    exp = {8'h0a, body};
    for (int k = 3; k >= 0; k--) exp.push_back(hexc(c[4*k +: 4], 1'b0));
    exp.push_back(8'h0d);
  endtask
  task automatic conclude();
    $display("checks %0d mismatches %0d", tests_run, errors);
    if (errors == 0 && tests_run > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  task automatic stop();
    errors++;
    conclude();
  endtask
  task automatic do_reset(input logic s);
    arst_n_in = 1'b0;
    sync_mode_in = s;
    repeat (12) @(negedge clk_in);
    arst_n_in = 1'b1;
    repeat (3) @(negedge clk_in);
  endtask
  task automatic send_net(input int n);
    int w;
    make(n);
    m.cap.delete();
    m.fl.delete();
    for (int i = 0; i < n; i++)
    begin
      @(negedge clk_in);
      tx_valid_in = 1'b1;
      tx_data_in = body[i];
      tx_last_in = (i == n - 1);
      for (w = 0; !tx_ready_out; w++)
      begin
        @(negedge clk_in);
        if (w > 900) stop();
      end
    end
    @(negedge clk_in);
    rej = tx_reject_out;
    tx_valid_in = 1'b0;
    tx_last_in = 1'b0;
  endtask
  // unused positions after the packet must be carriage returns
  task automatic chk_tx(input int len);
    int p, w;
    p = -1;
    for (w = 0; p < 0 || m.cap.size() < p + len; w++)
    begin
      @(negedge clk_in);
      if (w > 1500) stop();
      foreach (m.cap[i]) if (p < 0 && m.cap[i] === 8'h0a) p = i;
    end
    if (p > 0) `CHK("frame start", 1'b1, m.fl[p-1])
    for (int k = 0; k < len; k++)
    begin
      `CHK("link char", (k < exp.size()) ? exp[k] : 8'h0d, m.cap[p+k])
      `CHK("frame end", k == len - 1, m.fl[p+k])
    end
  endtask
  //////////////////////////////////////////////////////////////
  task automatic sc_async();
    stall = 1'b1;
    send_net(25);
    `CHK("short refused", 1'b1, rej)
    send_net(26);
    chk_tx(32);
    repeat (20) @(negedge clk_in);
    `CHK("no padding", 32, m.cap.size())
    `CHK("first char", 8'h0a, m.cap[0])
    send_net(251);
    `CHK("long refused", 1'b1, rej)
    send_net(250);
    chk_tx(256);
  endtask
  task automatic sc_rx(input int kind);
    int g, d, w;
    logic [15:0] c;
    make(26);
    c = crc_of() ^ ((kind == 1) ? 16'h0001 : 16'h0000);
    g = goods;
    d = drops;
    got.delete();
    lastn = 0;
    m.send(8'h0d, 1'b0);
    m.send(8'h51, 1'b0);
    for (int i = 0; i < 27; i++) m.send(exp[i], 1'b0);
    for (int k = 3; k >= 0; k--) m.send(hexc(c[4*k +: 4], 1'b1), kind == 2 && k == 0);
    if (kind != 2)
    begin
      repeat (6) m.send(8'h0d, 1'b0);
      m.send(8'h0d, 1'b1);
    end
    m.idle();
    for (w = 0; got.size() < 26 && drops == d; w++)
    begin
      @(negedge clk_in);
      if (w > 300) stop();
    end
    `CHK("passed", kind == 0, goods - g == 1)
    `CHK("dropped", kind != 0, drops - d == 1)
    `CHK("chars out", (kind == 0) ? 26 : 0, got.size())
    if (kind == 0)
    begin
      `CHK("last mark", 26, lastn)
      foreach (body[i]) `CHK("net char", body[i], got[i])
    end
  endtask
  task automatic sc_sync();
    stall = 1'b0;
    send_net(35);
    `CHK("oversize refused", 1'b1, rej)
    send_net(34);
    `CHK("fit accepted", 1'b0, rej)
    chk_tx(40);
  endtask
  //////////////////////////////////////////////////////////////
  initial
  begin
    clk_in = 1'b0;
    {tx_valid_in, tx_last_in, rx_ready_in, stall, rej} = 5'h00;
    tx_data_in = 8'h00;
    payload_length_chars_in = 9'h028;
    {errors, tests_run, goods, drops, lastn} = 0;
    do_reset(1'b0);
    sc_async();
    for (int k = 0; k < 3; k++) sc_rx(k);
    do_reset(1'b1);
    sc_sync();
    conclude();
  end
endmodule // test_clpf_framer
